// >>> boot_mux_pkg.sv
// shared constants, types and register map for the boot strap and pin mux block
package boot_mux_pkg;

  // widths and sizes
  localparam int GPIO_W = 12;
  localparam int MEM_DATA_W = 8;
  localparam int MEM_ADDR_W = 16;
  localparam int BOOT_LEN = 256;
  localparam int PROC_DIV = 4;

  // timing: external memory phase length, rounded up to whole cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int EXT_ACCESS_NS = 100;
  localparam int EXT_ACCESS_CYC = (EXT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INT_ST = 8'h08;
  localparam logic [7:0] OFS_INT_CLR = 8'h0C;
  localparam logic [7:0] OFS_INT_EN = 8'h10;
  localparam logic [7:0] OFS_DL_DATA = 8'h14;
  localparam logic [7:0] OFS_GPIO_OUT = 8'h18;
  localparam logic [7:0] OFS_GPIO_OE = 8'h1C;
  localparam logic [7:0] OFS_GPIO_IN = 8'h20;
  localparam logic [7:0] OFS_PEEK = 8'h24;

  // control register fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_MSG_BIT = 1;
  localparam int CTRL_SPECIAL_BIT = 2;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;

  // status register fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_BOOT_SRC_BIT = 2;
  localparam int ST_CLK_SRC_BIT = 3;
  localparam int ST_RUN_BIT = 4;
  localparam int ST_REQ_BIT = 5;
  localparam int ST_COUNT_LSB = 8;

  // interrupt fields, shared by status, clear and enable
  localparam int INT_BOOT_DONE_BIT = 0;
  localparam int INT_STRAP_ERR_BIT = 1;
  localparam int INT_W = 2;
  localparam logic [INT_W-1:0] INT_RST = 2'h0;

  // external memory strobe pins on the general purpose bank
  localparam int EM_LATCH_HI_PIN = 8;
  localparam int EM_LATCH_LO_PIN = 9;
  localparam int EM_READ_N_PIN = 10;

  typedef enum logic [1:0] {MODE_PAR_A, MODE_PAR_B, MODE_SER_2W, MODE_SER_4W} host_mode_e;
  typedef enum logic {PH_BOOT, PH_RUN} boot_phase_e;
  typedef enum logic [2:0] {LD_IDLE, LD_ADDR_HI, LD_ADDR_LO, LD_READ, LD_DONE} loader_state_e;

  typedef struct packed {
    logic [GPIO_W-1:0] o;
    logic [GPIO_W-1:0] oe;
  } gpio_drive_s;

  typedef struct packed {
    logic boot_src;
    logic clk_src;
    logic strap_err;
  } strap_s;

endpackage : boot_mux_pkg

// >>> ext_boot_loader.sv
// code store with autoboot reader over the multiplexed external memory bus
`timescale 1ns/1ps
`default_nettype none
module ext_boot_loader
  import boot_mux_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic host_wr,
  input wire logic [MEM_DATA_W-1:0] host_byte,
  input wire logic [MEM_DATA_W-1:0] mem_in,
  input wire logic [7:0] peek_addr,
  output logic [MEM_DATA_W-1:0] peek_data,
  output gpio_drive_s mem_drive,
  output logic done,
  output logic [MEM_ADDR_W-1:0] count
);

  localparam logic [7:0] ACC_CYC = 8'(EXT_ACCESS_CYC);
  localparam logic [MEM_ADDR_W-1:0] LAST_ADDR = MEM_ADDR_W'(BOOT_LEN - 1);

  logic [MEM_DATA_W-1:0] code_mem [BOOT_LEN];
  loader_state_e state_q, state_d;
  logic [MEM_ADDR_W-1:0] addr_q, addr_d;
  logic [7:0] wait_q, wait_d;
  gpio_drive_s drive_q, drive_d;
  logic mem_we;
  logic [7:0] mem_wa;
  logic [MEM_DATA_W-1:0] mem_wd;

  ////////////////////////////////////////////////////////////////////////////
  // address out high, address out low, then read strobe; one byte per round
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    wait_d = wait_q;
    drive_d = '0;
    mem_we = 1'b0;
    mem_wa = addr_q[7:0];
    mem_wd = mem_in;
    case (state_q)
      LD_IDLE: begin
        if (start) begin
          state_d = LD_ADDR_HI; // [RULE5]
          wait_d = ACC_CYC;
        end else if (host_wr) begin
          mem_we = 1'b1; // [RULE4]
          mem_wd = host_byte;
          addr_d = addr_q + 1'b1;
        end
      end
      LD_ADDR_HI, LD_ADDR_LO: begin
        // data lines carry an address byte, the matching latch strobe pulses
        drive_d.o[7:0] = (state_q == LD_ADDR_HI) ? addr_q[15:8] : addr_q[7:0]; // [RULE5]
        drive_d.oe[7:0] = 8'hFF;
        drive_d.o[EM_LATCH_HI_PIN] = (state_q == LD_ADDR_HI);
        drive_d.o[EM_LATCH_LO_PIN] = (state_q == LD_ADDR_LO);
        drive_d.o[EM_READ_N_PIN] = 1'b1;
        drive_d.oe[EM_READ_N_PIN:EM_LATCH_HI_PIN] = 3'h7;
        if (wait_q == 8'h01) begin
          state_d = (state_q == LD_ADDR_HI) ? LD_ADDR_LO : LD_READ;
          wait_d = ACC_CYC;
        end else begin
          wait_d = wait_q - 1'b1;
        end
      end
      LD_READ: begin
        // bus released, memory drives the byte while read strobe is low
        drive_d.o[EM_READ_N_PIN] = 1'b0;
        drive_d.oe[EM_READ_N_PIN:EM_LATCH_HI_PIN] = 3'h7;
        if (wait_q == 8'h01) begin
          mem_we = 1'b1; // [RULE5]
          wait_d = ACC_CYC;
          addr_d = addr_q + 1'b1;
          state_d = (addr_q == LAST_ADDR) ? LD_DONE : LD_ADDR_HI;
        end else begin
          wait_d = wait_q - 1'b1;
        end
      end
      LD_DONE: state_d = LD_DONE;
      default: state_d = LD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= LD_IDLE;
      addr_q <= '0;
      wait_q <= '0;
      drive_q <= '0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      wait_q <= wait_d;
      drive_q <= drive_d;
    end
  end

  // code store has no reset; contents are only meaningful once loaded
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      code_mem[mem_wa] <= mem_wd;
    end
  end

  assign peek_data = code_mem[peek_addr];
  assign mem_drive = drive_q;
  assign done = (state_q == LD_DONE);
  assign count = addr_q;

endmodule : ext_boot_loader
`default_nettype wire

// >>> boot_pin_mux.sv
// boot strap capture, boot sequencing, clock select and general purpose pin mux
// Operation
// RULE1 - external memory only in serial host modes
// RULE2 - clock strap low PLL, high direct input
// RULE3 - boot strap sampled at reset release
// RULE4 - strap high: host downloads code first
// RULE5 - strap low: autoboot reads bytes from memory
// RULE6 - after boot, pin requests host read message
// RULE7 - pins: parallel port or memory by mode
// RULE8 - serial modes: special use when application enables
// RULE9 - pins leave reset as undriven inputs
// RULE10 - read, write, select straps pick host mode
// RULE11 - direct clock quartered until boot ends
// RULE12 - request pin pulls low, else released
`timescale 1ns/1ps
`default_nettype none
module boot_pin_mux
  import boot_mux_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic boot_source_strap,
  output logic message_pending_request_o,
  output logic message_pending_request_oe,
  input wire logic clock_source_strap,
  input wire logic host_rd_strap,
  input wire logic host_wr_strap,
  input wire logic port_sel_strap,
  input wire logic [GPIO_W-1:0] gpio_i,
  input wire gpio_drive_s par_port_drive,
  output gpio_drive_s gpio_pins,
  output host_mode_e host_mode,
  output logic pll_clock_sel,
  output logic processor_clock_en,
  output logic irq
);

  // decode the host mode straps
  function automatic host_mode_e decode_mode(input logic rd, input logic wr, input logic ps);
    host_mode_e m;
    m = MODE_SER_2W;
    if (rd && wr) begin
      m = ps ? MODE_PAR_A : MODE_PAR_B;
    end else if (rd && !wr) begin
      m = MODE_SER_4W;
    end
    return m;
  endfunction : decode_mode

  function automatic logic is_serial(input host_mode_e m);
    return (m == MODE_SER_2W) || (m == MODE_SER_4W);
  endfunction : is_serial

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  strap_s strap_q, strap_d;
  host_mode_e mode_q, mode_d;
  logic rst_seen_q, rst_seen_d;
  boot_phase_e phase_q, phase_d;
  logic [1:0] div_q, div_d;
  logic clk_en_q, clk_en_d;
  logic pll_sel_q, pll_sel_d;
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [INT_W-1:0] int_st_q, int_st_d;
  logic [INT_W-1:0] int_en_q, int_en_d;
  logic [GPIO_W-1:0] gpio_out_q, gpio_out_d;
  logic [GPIO_W-1:0] gpio_oe_q, gpio_oe_d;
  logic [7:0] peek_q, peek_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic irq_q, irq_d;
  gpio_drive_s pins_q, pins_d;
  logic req_oe_q, req_oe_d;
  logic req_o_q, req_o_d;
  logic running;
  logic autoboot_path;
  logic release_evt;
  logic done_evt;
  logic wr_acc;
  logic setup;
  logic dl_wr;
  logic ld_start;
  logic ld_done;
  logic [MEM_ADDR_W-1:0] ld_count;
  logic [MEM_DATA_W-1:0] peek_data;
  gpio_drive_s ld_drive;
  logic [31:0] rd_mux;
  logic known;

  ////////////////////////////////////////////////////////////////////////////
  // strap capture: pins are followed while reset is high and frozen at release
  always_comb begin
    strap_d = strap_q;
    mode_d = mode_q;
    if (sys_rst) begin
      strap_d.boot_src = boot_source_strap; // [RULE3]
      strap_d.clk_src = clock_source_strap; // [RULE2]
      strap_d.strap_err = !host_rd_strap && !host_wr_strap; // [RULE10]
      mode_d = decode_mode(host_rd_strap, host_wr_strap, port_sel_strap); // [RULE10]
    end
    rst_seen_d = sys_rst;
  end

  // no reset branch: these flops load from the pins during reset itself
  always_ff @(posedge clk_sys) begin
    strap_q <= strap_d;
    mode_q <= mode_d;
    rst_seen_q <= rst_seen_d;
  end

  assign release_evt = rst_seen_q && !sys_rst;
  assign running = (phase_q == PH_RUN);
  // no memory bus in parallel modes, so autoboot falls back to host load
  assign autoboot_path = !strap_q.boot_src && is_serial(mode_q); // [RULE1] [RULE5]

  ////////////////////////////////////////////////////////////////////////////
  // boot phase and processor clock selection
  always_comb begin
    phase_d = phase_q;
    done_evt = 1'b0;
    if (phase_q == PH_BOOT) begin
      if ((autoboot_path && ld_done) || (!autoboot_path && ctrl_q[CTRL_RUN_BIT])) begin
        phase_d = PH_RUN; // [RULE4] [RULE5]
        done_evt = 1'b1;
      end
    end
    div_d = div_q + 2'h1;
    pll_sel_d = !strap_q.clk_src; // [RULE2]
    if (!strap_q.clk_src || running) begin
      clk_en_d = 1'b1; // [RULE11]
    end else begin
      clk_en_d = (div_q == 2'(PROC_DIV - 1)); // [RULE11]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      phase_q <= PH_BOOT;
      div_q <= 2'h0;
      clk_en_q <= 1'b0;
      pll_sel_q <= 1'b1;
    end else begin
      phase_q <= phase_d;
      div_q <= div_d;
      clk_en_q <= clk_en_d;
      pll_sel_q <= pll_sel_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boot code store and external memory reader
  assign ld_start = !sys_rst && (phase_q == PH_BOOT) && autoboot_path; // [RULE5]
  assign dl_wr = wr_acc && hit(paddr, OFS_DL_DATA) && (phase_q == PH_BOOT) && !autoboot_path;

  ext_boot_loader u_loader (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .start(ld_start),
    .host_wr(dl_wr),
    .host_byte(pwdata[7:0]),
    .mem_in(gpio_i[7:0]),
    .peek_addr(peek_q),
    .peek_data(peek_data),
    .mem_drive(ld_drive),
    .done(ld_done),
    .count(ld_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: read data is sampled in setup, so every access has no wait
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready_q && pwrite;
  assign known = hit(paddr, OFS_CTRL) || hit(paddr, OFS_STATUS) || hit(paddr, OFS_INT_ST)
              || hit(paddr, OFS_INT_CLR) || hit(paddr, OFS_INT_EN) || hit(paddr, OFS_DL_DATA)
              || hit(paddr, OFS_GPIO_OUT) || hit(paddr, OFS_GPIO_OE)
              || hit(paddr, OFS_GPIO_IN) || hit(paddr, OFS_PEEK);

  // read multiplexer; write-only and unmapped words read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_CTRL: rd_mux[CTRL_W-1:0] = ctrl_q;
      OFS_STATUS: begin
        rd_mux[ST_MODE_LSB +: 2] = mode_q;
        rd_mux[ST_BOOT_SRC_BIT] = strap_q.boot_src;
        rd_mux[ST_CLK_SRC_BIT] = strap_q.clk_src;
        rd_mux[ST_RUN_BIT] = running;
        rd_mux[ST_REQ_BIT] = req_oe_q;
        rd_mux[ST_COUNT_LSB +: MEM_ADDR_W] = ld_count;
      end
      OFS_INT_ST: rd_mux[INT_W-1:0] = int_st_q;
      OFS_INT_EN: rd_mux[INT_W-1:0] = int_en_q;
      OFS_GPIO_OUT: rd_mux[GPIO_W-1:0] = gpio_out_q;
      OFS_GPIO_OE: rd_mux[GPIO_W-1:0] = gpio_oe_q;
      OFS_GPIO_IN: rd_mux[GPIO_W-1:0] = gpio_i;
      OFS_PEEK: rd_mux[MEM_DATA_W-1:0] = peek_data;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // register writes and sticky interrupt status; a new event beats its clear
  always_comb begin
    pready_d = setup;
    pslverr_d = setup && !known;
    prdata_d = (setup && !pwrite) ? rd_mux : prdata_q;
    ctrl_d = ctrl_q;
    int_en_d = int_en_q;
    gpio_out_d = gpio_out_q;
    gpio_oe_d = gpio_oe_q;
    peek_d = peek_q;
    int_st_d = int_st_q;
    if (wr_acc) begin
      if (hit(paddr, OFS_CTRL)) ctrl_d = pwdata[CTRL_W-1:0];
      if (hit(paddr, OFS_INT_EN)) int_en_d = pwdata[INT_W-1:0];
      if (hit(paddr, OFS_GPIO_OUT)) gpio_out_d = pwdata[GPIO_W-1:0];
      if (hit(paddr, OFS_GPIO_OE)) gpio_oe_d = pwdata[GPIO_W-1:0];
      if (hit(paddr, OFS_PEEK)) peek_d = pwdata[7:0];
      if (hit(paddr, OFS_INT_CLR)) int_st_d = int_st_q & ~pwdata[INT_W-1:0];
    end
    if (done_evt) int_st_d[INT_BOOT_DONE_BIT] = 1'b1;
    if (release_evt && strap_q.strap_err) int_st_d[INT_STRAP_ERR_BIT] = 1'b1;
    irq_d = |(int_st_q & int_en_q);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      ctrl_q <= CTRL_RST;
      int_en_q <= INT_RST;
      int_st_q <= INT_RST;
      gpio_out_q <= '0;
      gpio_oe_q <= '0;
      peek_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      ctrl_q <= ctrl_d;
      int_en_q <= int_en_d;
      int_st_q <= int_st_d;
      gpio_out_q <= gpio_out_d;
      gpio_oe_q <= gpio_oe_d;
      peek_q <= peek_d;
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-pin owner select; pins lag their source by one registered cycle
  genvar gi;
  generate
    for (gi = 0; gi < GPIO_W; gi++) begin : g_pin
      always_comb begin
        pins_d.o[gi] = 1'b0;
        pins_d.oe[gi] = 1'b0; // [RULE9]
        if (!sys_rst) begin
          if (!is_serial(mode_q)) begin
            pins_d.o[gi] = par_port_drive.o[gi]; // [RULE7]
            pins_d.oe[gi] = par_port_drive.oe[gi];
          end else if (!running) begin
            pins_d.o[gi] = ld_drive.o[gi]; // [RULE1] [RULE7]
            pins_d.oe[gi] = ld_drive.oe[gi];
          end else if (ctrl_q[CTRL_SPECIAL_BIT]) begin
            pins_d.o[gi] = gpio_out_q[gi]; // [RULE8]
            pins_d.oe[gi] = gpio_oe_q[gi];
          end
        end
      end
    end
  endgenerate

  // request pin only pulls low; the pull-up gives the idle high level
  always_comb begin
    req_o_d = 1'b0; // [RULE12]
    req_oe_d = !sys_rst && running && ctrl_q[CTRL_MSG_BIT]; // [RULE6] [RULE12]
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pins_q <= '0;
      req_oe_q <= 1'b0;
      req_o_q <= 1'b0;
    end else begin
      pins_q <= pins_d;
      req_oe_q <= req_oe_d;
      req_o_q <= req_o_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign message_pending_request_o = req_o_q;
  assign message_pending_request_oe = req_oe_q;
  assign gpio_pins = pins_q;
  assign host_mode = mode_q;
  assign pll_clock_sel = pll_sel_q;
  assign processor_clock_en = clk_en_q;
  assign irq = irq_q;

endmodule : boot_pin_mux
`default_nettype wire

// >>> boot_pin_mux_props.sv
// checker: strap capture, pin ownership, boot bus phases and request pin
`timescale 1ns/1ps
`default_nettype none
module boot_pin_mux_props
  import boot_mux_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic host_rd_strap,
  input wire logic host_wr_strap,
  input wire logic port_sel_strap,
  input wire logic clock_source_strap,
  input wire gpio_drive_s par_port_drive,
  input wire gpio_drive_s gpio_pins,
  input wire host_mode_e host_mode,
  input wire logic pll_clock_sel,
  input wire logic processor_clock_en,
  input wire logic message_pending_request_o,
  input wire logic message_pending_request_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic clk_cap_q;
  logic hi;
  logic lo;
  logic rd;
  host_mode_e exp_mode;
  ////////////////////////////////////////////////////////////////////////////
  // clock strap as held on the last reset edge
  always_ff @(posedge clk_sys) begin
    if (sys_rst) clk_cap_q <= clock_source_strap;
  end
  // mode decode from the raw straps; rd=wr=0 falls back to two-wire
  always_comb begin
    if (host_rd_strap && host_wr_strap) exp_mode = port_sel_strap ? MODE_PAR_A : MODE_PAR_B;
    else if (host_rd_strap) exp_mode = MODE_SER_4W;
    else exp_mode = MODE_SER_2W;
  end
  // memory strobes as seen on the pins
  assign hi = gpio_pins.oe[EM_LATCH_HI_PIN] & gpio_pins.o[EM_LATCH_HI_PIN];
  assign lo = gpio_pins.oe[EM_LATCH_LO_PIN] & gpio_pins.o[EM_LATCH_LO_PIN];
  assign rd = gpio_pins.oe[EM_READ_N_PIN] & ~gpio_pins.o[EM_READ_N_PIN] & ~hi & ~lo;
  ////////////////////////////////////////////////////////////////////////////
  chk_mode_decode: assert property ($fell(sys_rst) |-> host_mode == $past(exp_mode))
    else $error("host mode differs from latched straps");
  chk_mode_hold: assert property (!$past(sys_rst) |-> $stable(host_mode))
    else $error("host mode moved after reset release");
  chk_clk_source: assert property (!$past(sys_rst) |-> pll_clock_sel == !clk_cap_q)
    else $error("clock source does not follow strap");
  chk_div_gap: assert property ($fell(processor_clock_en) && !pll_clock_sel
    |-> ##[1:3] processor_clock_en) else $error("direct clock gap too long");
  chk_par_owner: assert property (host_mode inside {MODE_PAR_A, MODE_PAR_B} &&
    !$past(sys_rst) |-> gpio_pins == $past(par_port_drive)) else $error("pins not host port");
  chk_phase_hi: assert property ($rose(hi) |-> ##9 hi ##1 (lo && !hi))
    else $error("address high phase length wrong");
  chk_phase_lo: assert property ($rose(lo) |-> ##9 lo ##1 rd)
    else $error("address low phase length wrong");
  chk_bus_dir: assert property ((hi || lo) |-> &gpio_pins.oe[7:0] && !rd)
    else $error("address not driven in address phase");
  chk_pins_reset: assert property ($fell(sys_rst) |-> gpio_pins.oe == '0 &&
    !message_pending_request_oe) else $error("pins driven out of reset");
  chk_req_quiet: assert property ($fell(sys_rst) |-> !message_pending_request_oe [*8])
    else $error("request pin active during boot");
  chk_req_drain: assert property (message_pending_request_oe |-> !message_pending_request_o)
    else $error("request pin drives high");
  // main scenarios reached
  cov_read: cover property (rd ##1 !rd);
  cov_req: cover property (message_pending_request_oe);
  cov_par: cover property ($fell(sys_rst) ##1 host_mode == MODE_PAR_A);
endmodule : boot_pin_mux_props
`default_nettype wire

// >>> boot_mem_model.sv
// byte-wide boot memory on the multiplexed address/data pins
`timescale 1ns/1ps
`default_nettype none
module boot_mem_model
  import boot_mux_pkg::*;
(
  input wire logic clk_sys,
  input wire gpio_drive_s pins,
  output logic [MEM_DATA_W-1:0] data_o
);
  logic [MEM_ADDR_W-1:0] addr_q = '0;
  logic [MEM_DATA_W-1:0] last_q = '0;
  logic reading;
  // image byte is a fixed scramble of its address
  function automatic logic [MEM_DATA_W-1:0] image(input logic [MEM_ADDR_W-1:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction : image
  assign reading = pins.oe[EM_READ_N_PIN] & ~pins.o[EM_READ_N_PIN];
  // address halves latched on their strobes; plain always keeps the initial values legal
  always @(posedge clk_sys) begin
    if (pins.oe[EM_LATCH_HI_PIN] && pins.o[EM_LATCH_HI_PIN]) addr_q[15:8] <= pins.o[7:0];
    if (pins.oe[EM_LATCH_LO_PIN] && pins.o[EM_LATCH_LO_PIN]) addr_q[7:0] <= pins.o[7:0];
    if (reading) last_q <= image(addr_q);
  end
  // released bus shows the inverse, so a stale byte is never mistaken
  assign data_o = reading ? image(addr_q) : ~last_q;
endmodule : boot_mem_model
`default_nettype wire

// >>> testbench.sv
// testbench: autoboot, host download, pin ownership and request pin
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import boot_mux_pkg::*;
  logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, err_q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic boot_sel, clock_source_strap, host_rd_strap, host_wr_strap, port_sel_strap;
  logic msg_o, msg_oe, pin_lvl, boot_pin, pll_clock_sel, processor_clock_en, irq;
  logic [GPIO_W-1:0] gpio_i;
  logic [MEM_DATA_W-1:0] mem_data;
  gpio_drive_s par_port_drive, gpio_pins;
  host_mode_e host_mode;
  int err_total = 0;
  int n_checks = 0;
  ////////////////////////////////////////////////////////////////////////////
  // open-drain pin with pull-up; strap value only while reset holds
  assign pin_lvl = msg_oe ? msg_o : 1'b1;
  assign boot_pin = sys_rst ? boot_sel : pin_lvl;
  // undriven upper pins pulled up, lower pins from the memory
  assign gpio_i = (gpio_pins.oe & gpio_pins.o) | (~gpio_pins.oe & {4'hF, mem_data});
  boot_pin_mux u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .boot_source_strap(boot_pin), .message_pending_request_o(msg_o),
    .message_pending_request_oe(msg_oe), .clock_source_strap(clock_source_strap),
    .host_rd_strap(host_rd_strap), .host_wr_strap(host_wr_strap),
    .port_sel_strap(port_sel_strap), .gpio_i(gpio_i), .par_port_drive(par_port_drive),
    .gpio_pins(gpio_pins), .host_mode(host_mode), .pll_clock_sel(pll_clock_sel),
    .processor_clock_en(processor_clock_en), .irq(irq));
  boot_mem_model u_mem (.clk_sys(clk_sys), .pins(gpio_pins), .data_o(mem_data));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one transfer; an idle edge after it keeps psel from being set twice at once
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // a slave that never answers is a failure, not a silent skip
    if (pready !== 1'b1) err_total++;
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic do_reset(input logic [2:0] rws, input logic bt, input logic ck);
    {host_rd_strap, host_wr_strap, port_sel_strap} <= rws;
    boot_sel <= bt;
    clock_source_strap <= ck;
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    chk(gpio_pins.oe, '0);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
  endtask : do_reset
  task automatic t_autoboot();
    logic [31:0] idx [4] = '{0, 1, 128, 255};
    int n;
    do_reset(3'b010, 1'b0, 1'b0);
    host_rd_strap <= 1'b1;
    apb(OFS_INT_EN, 1'b1, 32'h3);
    n = 0;
    while (irq !== 1'b1 && n < 9000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(irq, 1'b1);
    chk(host_mode, MODE_SER_2W);
    chk(pll_clock_sel, 1'b1);
    chk(gpio_pins.oe, '0);
    apb(OFS_STATUS, 1'b0, '0);
    chk(rd_q, 32'h0001_0012);
    foreach (idx[i]) begin
      apb(OFS_PEEK, 1'b1, idx[i]);
      apb(OFS_PEEK, 1'b0, '0);
      chk(rd_q, idx[i] ^ 32'hA5);
    end
    apb(OFS_INT_CLR, 1'b1, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
  endtask : t_autoboot
  task automatic t_request();
    apb(OFS_CTRL, 1'b1, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk(pin_lvl, 1'b0);
    apb(OFS_CTRL, 1'b1, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk(pin_lvl, 1'b1);
    apb(OFS_GPIO_OUT, 1'b1, 32'h45C);
    apb(OFS_GPIO_OE, 1'b1, 32'hC3C);
    apb(OFS_CTRL, 1'b1, 32'h4);
    repeat (2) @(posedge clk_sys);
    chk(gpio_pins.o & gpio_pins.oe, 12'h41C);
    apb(OFS_CTRL, 1'b1, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk(gpio_pins.oe, '0);
    apb(8'h40, 1'b0, '0);
    chk(err_q, 1'b1);
    chk(rd_q, 32'h0000_0000);
  endtask : t_request
  task automatic t_parallel();
    int cnt;
    do_reset(3'b111, 1'b0, 1'b1);
    par_port_drive <= {12'h3C5, 12'h0FF};
    cnt = 0;
    repeat (40) begin
      @(posedge clk_sys);
      if (processor_clock_en === 1'b1) cnt++;
    end
    chk(cnt, 10);
    chk(gpio_pins, {12'h3C5, 12'h0FF});
    apb(OFS_DL_DATA, 1'b1, 32'h11);
    apb(OFS_DL_DATA, 1'b1, 32'h22);
    apb(OFS_CTRL, 1'b1, 32'h1);
    // enable still shows the boot pattern one edge after run is set
    @(posedge clk_sys);
    cnt = 0;
    repeat (20) begin
      @(posedge clk_sys);
      if (processor_clock_en === 1'b1) cnt++;
    end
    chk(cnt, 20);
    apb(OFS_STATUS, 1'b0, '0);
    chk(rd_q, 32'h0000_0218);
    apb(OFS_PEEK, 1'b1, 32'h1);
    apb(OFS_PEEK, 1'b0, '0);
    chk(rd_q, 32'h22);
  endtask : t_parallel
  task automatic t_modes();
    logic [2:0] rws [3] = '{3'b110, 3'b101, 3'b000};
    host_mode_e md [3] = '{MODE_PAR_B, MODE_SER_4W, MODE_SER_2W};
    do_reset(3'b010, 1'b0, 1'b0);
    repeat (500) @(posedge clk_sys);
    for (int i = 0; i < 3; i++) begin
      do_reset(rws[i], 1'b1, 1'b0);
      chk(host_mode, md[i]);
      apb(OFS_STATUS, 1'b0, '0);
      chk(rd_q[3:0], 4'h4 | 4'(md[i]));
      apb(OFS_INT_ST, 1'b0, '0);
      chk(rd_q[1], rws[i] == 3'b000);
    end
  endtask : t_modes
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////
  // main sequence; every input has a value at time zero
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    boot_sel = 1'b0;
    clock_source_strap = 1'b0;
    {host_rd_strap, host_wr_strap, port_sel_strap} = 3'b010;
    par_port_drive = '0;
    @(posedge clk_sys);
    t_autoboot();
    t_request();
    t_parallel();
    t_modes();
    give_verdict();
  end
  // hang guard, well beyond one autoboot plus the short scenarios
  initial begin
    #400000;
    err_total++;
    give_verdict();
  end
endmodule : testbench
bind boot_pin_mux boot_pin_mux_props u_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .host_rd_strap(host_rd_strap), .host_wr_strap(host_wr_strap),
  .port_sel_strap(port_sel_strap), .clock_source_strap(clock_source_strap),
  .par_port_drive(par_port_drive), .gpio_pins(gpio_pins), .host_mode(host_mode),
  .pll_clock_sel(pll_clock_sel), .processor_clock_en(processor_clock_en),
  .message_pending_request_o(message_pending_request_o),
  .message_pending_request_oe(message_pending_request_oe));
`default_nettype wire
